// ===== include/pppm_map.vh
/*
  Register offsets, field positions, reset values, codes and wait
  counts of the parallel port polarity and mode block.
  Assumes inclusion by bare name from every design file of the block.
*/
`ifndef PPPM_MAP_VH
`define PPPM_MAP_VH

`define PPPM_OFS_CTRL      4'h0
`define PPPM_OFS_MODE      4'h1
`define PPPM_OFS_ADDR      4'h2
`define PPPM_OFS_DATA      4'h3
`define PPPM_OFS_IRQ_STAT  4'h4
`define PPPM_OFS_IRQ_CLR   4'h5
`define PPPM_OFS_IRQ_EN    4'h6
`define PPPM_OFS_BUF0      4'h8

`define PPPM_CTRL_RST      16'h0000
`define PPPM_CTRL_WMASK    16'h8707
`define PPPM_MODE_RST      16'h0000
`define PPPM_MODE_WMASK    16'h7FFF

`define PPPM_CTRL_EN       15
`define PPPM_CTRL_BE_PORT  10
`define PPPM_CTRL_WR_PORT  9
`define PPPM_CTRL_RD_PORT  8
`define PPPM_CTRL_BEP      2
`define PPPM_CTRL_WRITE_STROBE_POLARITY     1
`define PPPM_CTRL_READ_STROBE_POLARITY     0

`define PPPM_MODE_BUSY     15
`define PPPM_MODE_INTERRUPT_REQUEST_SELECT     13
`define PPPM_MODE_ADDRESS_STEP_SELECT     11
`define PPPM_MODE_WIDE     10
`define PPPM_MODE_MODE     8
`define PPPM_MODE_SETUP_WAIT_COUNT    6
`define PPPM_MODE_STROBE_WAIT_COUNT    2
`define PPPM_MODE_HOLD_WAIT_COUNT    0

`define PPPM_PM_SLAVE_LEG  2'h0
`define PPPM_PM_SLAVE_BUF  2'h1
`define PPPM_PM_MASTER2    2'h2
`define PPPM_PM_MASTER1    2'h3

`define PPPM_INC_NONE      2'h0
`define PPPM_INC_UP        2'h1
`define PPPM_INC_DOWN      2'h2
`define PPPM_INC_BUF       2'h3

`define PPPM_IRQ_CYCLE     2'h1
`define PPPM_IRQ_BUF3      2'h3

`define PPPM_EV_CYCLE      0
`define PPPM_EV_BUF3       1

`define PPPM_WAIT_BASE     4'h0

`endif

// ===== rtl/pppm_addr_step.v
/*
  Address step after each master read/write cycle.
  Assumes the step code comes straight from the mode register.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pppm_map.vh"

module pppm_addr_step (
  input  wire [15:0] addr,
  input  wire [1:0]  step_sel,
  output reg  [15:0] addr_nxt
);
  // Bit 14 is left alone; the other fifteen bits count as one value
  wire [14:0] packed_a;
  wire [14:0] up_a;
  wire [14:0] down_a;

  assign packed_a = {addr[15], addr[13:0]};
  assign up_a     = packed_a + 15'h0001;
  assign down_a   = packed_a - 15'h0001;

  always @* begin
    case (step_sel)
      `PPPM_INC_UP:   addr_nxt = {up_a[14], addr[14], up_a[13:0]};
      `PPPM_INC_DOWN: addr_nxt = {down_a[14], addr[14], down_a[13:0]};
      default:        addr_nxt = addr;
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/pppm_strobe_pol.v
/*
  Strobe and byte-enable polarity and pin function selection.
  Assumes active-true strobes from the transfer sequencer and
  synchronous pin inputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pppm_map.vh"

module pppm_strobe_pol (
  input  wire [1:0] port_mode,
  input  wire       master,
  input  wire       byte_enable_polarity,
  input  wire       write_strobe_polarity,
  input  wire       read_strobe_polarity,
  input  wire       be_port_en,
  input  wire       wr_port_en,
  input  wire       rd_port_en,
  input  wire [2:0] addr_hi,
  input  wire       be_act,
  input  wire       wr_act,
  input  wire       rd_act,
  input  wire       en_act,
  input  wire       dir_read,
  input  wire       wr_pin_i,
  input  wire       rd_pin_i,
  output wire       byte_enable_pin,
  output wire       write_strobe_pin,
  output wire       write_strobe_oe,
  output wire       read_strobe_pin,
  output wire       read_strobe_oe,
  output wire       slave_wr_act,
  output wire       slave_rd_act
);
  // Same mapping serves both directions: active level to pin and back
  function pol;
    input act;
    input p;
    begin
      pol = p ? act : ~act;
    end
  endfunction

  wire m1;
  wire wr_lvl;
  wire rd_lvl;

  assign m1 = (port_mode == `PPPM_PM_MASTER1);
  assign wr_lvl = m1 ? pol(en_act, write_strobe_polarity)
                     : pol(wr_act, write_strobe_polarity);
  assign rd_lvl = m1 ? pol(dir_read & en_act | dir_read, read_strobe_polarity)
                     : pol(rd_act, read_strobe_polarity);

  assign byte_enable_pin  = be_port_en ? pol(be_act, byte_enable_polarity)
                                       : addr_hi[0];
  assign write_strobe_pin = wr_port_en ? wr_lvl : addr_hi[1];
  assign read_strobe_pin  = rd_port_en ? rd_lvl : addr_hi[2];
  assign write_strobe_oe  = master;
  assign read_strobe_oe   = master;

  assign slave_wr_act = ~master & wr_port_en & pol(wr_pin_i, write_strobe_polarity);
  assign slave_rd_act = ~master & rd_port_en & pol(rd_pin_i, read_strobe_polarity);
endmodule
`default_nettype wire

// ===== rtl/pppm_top.v
/*
  Parallel port with programmable strobe polarity and mode: register
  file, master transfer sequencer, slave strobe capture, interrupt.
  Assumes one clock mclk, synchronous pin inputs, a single-cycle
  register port master and a testbench that resolves the pins.
*/
// Behaviour
// - Byte-enable pin level follows its polarity bit: 1 high-active, 0 low-active.
// - Outside first master mode, write polarity bit sets write strobe level.
// - In first master mode, write polarity bit sets the enable strobe level.
// - Outside first master mode, read polarity bit sets read strobe level.
// - In first master mode, read polarity bit sets combined read/write level.
// - Polarity bits do nothing while their pin carries an address bit.
// - Step field: 01 add one, 10 subtract, 00 hold, 11 buffer pointer.
`timescale 1ns/10ps
`default_nettype none
`include "pppm_map.vh"

module pppm_top #(
  parameter AW = 4,
  parameter DW = 16
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire [AW-1:0] reg_addr,
  input  wire [DW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output wire [DW-1:0] reg_rdata,
  output wire [15:0]   port_address_pins,
  output wire [15:0]   port_data_o,
  output wire          port_data_oe,
  input  wire [15:0]   port_data_i,
  output wire          byte_enable_pin,
  output wire          write_strobe_pin,
  output wire          write_strobe_oe,
  input  wire          write_strobe_i,
  output wire          read_strobe_pin,
  output wire          read_strobe_oe,
  input  wire          read_strobe_i,
  output wire          irq
);
  localparam S_IDLE  = 2'b00;
  localparam S_SETUP = 2'b01;
  localparam S_STRB  = 2'b10;
  localparam S_HOLD  = 2'b11;

  reg  [15:0] ctrl_r;
  reg  [15:0] mode_r;
  reg  [15:0] addr_r;
  reg  [15:0] rbuf_r;
  reg  [15:0] wbuf_r;
  reg  [15:0] dout_r;
  reg  [1:0]  irq_stat_r;
  reg  [1:0]  irq_stat_nxt;
  reg  [1:0]  irq_en_r;
  reg  [15:0] rdata_r;
  reg  [15:0] rdata_nxt;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [3:0]  cnt_r;
  reg  [3:0]  cnt_nxt;
  reg         dir_rd_r;
  reg  [1:0]  ptr_r;
  reg         s_wr_q_r;
  reg         s_rd_q_r;
  reg  [15:0] buf_mem [0:3];

  wire        enabled;
  wire [1:0]  port_mode;
  wire        master;
  wire [1:0]  interrupt_request_select;
  wire [1:0]  address_step_select;
  wire        wide;
  wire [3:0]  setup_wait_count;
  wire [3:0]  strobe_wait_count;
  wire [3:0]  hold_wait_count;
  wire        busy;
  wire        sel_data;
  wire        wr_data;
  wire        rd_data;
  wire        start;
  wire        m_done;
  wire        s_wr_act;
  wire        s_rd_act;
  wire        s_wr_pin;
  wire        s_rd_pin;
  wire        s_wr_end;
  wire        s_rd_end;
  wire        s_done;
  wire        cyc_done;
  wire        at_buf3;
  wire [15:0] addr_stepped;
  wire [1:0]  ev;
  wire        be_act;
  wire        wr_act;
  wire        rd_act;
  wire        en_act;

  function [3:0] fld4;
    input [15:0] r;
    input integer lsb;
    input [3:0] msk;
    begin
      fld4 = r[lsb +: 4] & msk;
    end
  endfunction

  assign enabled   = ctrl_r[`PPPM_CTRL_EN];
  assign port_mode = mode_r[`PPPM_MODE_MODE +: 2];
  assign master    = enabled & port_mode[1];
  assign interrupt_request_select      = mode_r[`PPPM_MODE_INTERRUPT_REQUEST_SELECT +: 2];
  assign address_step_select      = mode_r[`PPPM_MODE_ADDRESS_STEP_SELECT +: 2];
  assign wide      = mode_r[`PPPM_MODE_WIDE];
  assign setup_wait_count     = fld4(mode_r, `PPPM_MODE_SETUP_WAIT_COUNT, 4'h3);
  assign strobe_wait_count     = fld4(mode_r, `PPPM_MODE_STROBE_WAIT_COUNT, 4'hF);
  assign hold_wait_count     = fld4(mode_r, `PPPM_MODE_HOLD_WAIT_COUNT, 4'h3);
  assign busy      = (state_r != S_IDLE);

  assign sel_data  = (reg_addr == `PPPM_OFS_DATA);
  assign wr_data   = reg_wr & sel_data;
  assign rd_data   = reg_rd & sel_data;
  // A request while busy is dropped; software polls the busy flag first
  assign start     = master & ~busy & (wr_data | rd_data);

  // Master sequencer: setup, strobe, hold, each WAIT field plus one cycle
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      S_IDLE: begin
        if (start) begin
          state_nxt = S_SETUP;
          cnt_nxt   = setup_wait_count;
        end
      end
      S_SETUP: begin
        if (cnt_r == `PPPM_WAIT_BASE) begin
          state_nxt = S_STRB;
          cnt_nxt   = strobe_wait_count;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      S_STRB: begin
        if (cnt_r == `PPPM_WAIT_BASE) begin
          state_nxt = S_HOLD;
          cnt_nxt   = hold_wait_count;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      S_HOLD: begin
        if (cnt_r == `PPPM_WAIT_BASE) begin
          state_nxt = S_IDLE;
          cnt_nxt   = 4'h0;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = S_IDLE;
        cnt_nxt   = 4'h0;
      end
    endcase
  end

  assign m_done = (state_r == S_HOLD) & (cnt_r == `PPPM_WAIT_BASE);

  // Internal strobes are active-true; polarity is applied at the pins
  assign be_act = master & wide & busy;
  assign en_act = (state_r == S_STRB);
  assign wr_act = en_act & ~dir_rd_r;
  assign rd_act = en_act & dir_rd_r;

  pppm_strobe_pol u_pol (
    .port_mode             (port_mode),
    .master                (master),
    .byte_enable_polarity  (ctrl_r[`PPPM_CTRL_BEP]),
    .write_strobe_polarity (ctrl_r[`PPPM_CTRL_WRITE_STROBE_POLARITY]),
    .read_strobe_polarity  (ctrl_r[`PPPM_CTRL_READ_STROBE_POLARITY]),
    .be_port_en            (ctrl_r[`PPPM_CTRL_BE_PORT]),
    .wr_port_en            (ctrl_r[`PPPM_CTRL_WR_PORT]),
    .rd_port_en            (ctrl_r[`PPPM_CTRL_RD_PORT]),
    .addr_hi               (addr_r[15:13]),
    .be_act                (be_act),
    .wr_act                (wr_act),
    .rd_act                (rd_act),
    .en_act                (en_act),
    .dir_read              (dir_rd_r & busy),
    .wr_pin_i              (write_strobe_i),
    .rd_pin_i              (read_strobe_i),
    .byte_enable_pin       (byte_enable_pin),
    .write_strobe_pin      (write_strobe_pin),
    .write_strobe_oe       (write_strobe_oe),
    .read_strobe_pin       (read_strobe_pin),
    .read_strobe_oe        (read_strobe_oe),
    .slave_wr_act          (s_wr_pin),
    .slave_rd_act          (s_rd_pin)
  );

  pppm_addr_step u_step (
    .addr     (addr_r),
    .step_sel (address_step_select),
    .addr_nxt (addr_stepped)
  );

  // A disabled port must not capture host strobes left at an active level
  assign s_wr_act = enabled & s_wr_pin;
  assign s_rd_act = enabled & s_rd_pin;

  // Slave cycles complete when the host releases its strobe
  assign s_wr_end = enabled & s_wr_q_r & ~s_wr_act;
  assign s_rd_end = enabled & s_rd_q_r & ~s_rd_act;
  assign s_done   = s_wr_end | s_rd_end;
  assign cyc_done = m_done | s_done;
  assign at_buf3  = s_done & (ptr_r == 2'h3);

  assign ev[`PPPM_EV_CYCLE] = cyc_done & (interrupt_request_select == `PPPM_IRQ_CYCLE);
  assign ev[`PPPM_EV_BUF3]  = at_buf3 & (interrupt_request_select == `PPPM_IRQ_BUF3);

  // Set beats clear so an event landing on a clear write is kept
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && reg_addr == `PPPM_OFS_IRQ_CLR) begin
      irq_stat_nxt = irq_stat_nxt & ~reg_wdata[1:0];
    end
    irq_stat_nxt = irq_stat_nxt | ev;
  end

  assign irq = |(irq_stat_r & irq_en_r);

  always @* begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `PPPM_OFS_CTRL:     rdata_nxt = ctrl_r;
        `PPPM_OFS_MODE:     rdata_nxt = {busy, mode_r[14:0]};
        `PPPM_OFS_ADDR:     rdata_nxt = addr_r;
        `PPPM_OFS_DATA:     rdata_nxt = rbuf_r;
        `PPPM_OFS_IRQ_STAT: rdata_nxt = {14'h0000, irq_stat_r};
        `PPPM_OFS_IRQ_EN:   rdata_nxt = {14'h0000, irq_en_r};
        `PPPM_OFS_BUF0:     rdata_nxt = buf_mem[0];
        4'h9:               rdata_nxt = buf_mem[1];
        4'hA:               rdata_nxt = buf_mem[2];
        4'hB:               rdata_nxt = buf_mem[3];
        default:            rdata_nxt = 16'h0000;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r     <= `PPPM_CTRL_RST;
      mode_r     <= `PPPM_MODE_RST;
      irq_en_r   <= 2'h0;
      irq_stat_r <= 2'h0;
      rdata_r    <= 16'h0000;
      state_r    <= S_IDLE;
      cnt_r      <= 4'h0;
      dir_rd_r   <= 1'b0;
      s_wr_q_r   <= 1'b0;
      s_rd_q_r   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `PPPM_OFS_CTRL) begin
        ctrl_r <= reg_wdata & `PPPM_CTRL_WMASK;
      end
      if (reg_wr && reg_addr == `PPPM_OFS_MODE) begin
        mode_r <= reg_wdata & `PPPM_MODE_WMASK;
      end
      if (reg_wr && reg_addr == `PPPM_OFS_IRQ_EN) begin
        irq_en_r <= reg_wdata[1:0];
      end
      irq_stat_r <= irq_stat_nxt;
      rdata_r    <= rdata_nxt;
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      if (start) begin
        dir_rd_r <= rd_data;
      end
      s_wr_q_r <= s_wr_act;
      s_rd_q_r <= s_rd_act;
    end
  end

  // Data path registers hold no control state, so they reset plainly too
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_r <= 16'h0000;
      rbuf_r <= 16'h0000;
      wbuf_r <= 16'h0000;
      dout_r <= 16'h0000;
      ptr_r  <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `PPPM_OFS_ADDR) begin
        addr_r <= reg_wdata;
      end else if (m_done) begin
        addr_r <= addr_stepped;
      end
      if (wr_data) begin
        wbuf_r <= reg_wdata;
      end
      if (state_r == S_STRB && cnt_r == `PPPM_WAIT_BASE && dir_rd_r) begin
        rbuf_r <= wide ? port_data_i : {8'h00, port_data_i[7:0]};
      end else if (s_wr_act && !s_wr_q_r) begin
        rbuf_r <= port_data_i;
      end
      if (start && wr_data) begin
        dout_r <= wide ? reg_wdata : {8'h00, reg_wdata[7:0]};
      end else if (!master) begin
        dout_r <= buf_mem[ptr_r];
      end
      if (s_done && address_step_select == `PPPM_INC_BUF) begin
        ptr_r <= ptr_r + 2'h1;
      end else if (address_step_select != `PPPM_INC_BUF) begin
        ptr_r <= 2'h0;
      end
    end
  end

  // Buffers take host writes over software writes in the same cycle
  always @(posedge mclk) begin
    if (s_wr_act && !s_wr_q_r) begin
      buf_mem[ptr_r] <= port_data_i;
    end else if (reg_wr && reg_addr[3:2] == 2'b10) begin
      buf_mem[reg_addr[1:0]] <= reg_wdata;
    end
  end

  assign port_address_pins = addr_r;
  assign port_data_o       = dout_r;
  assign port_data_oe      = (master & busy & ~dir_rd_r) | s_rd_act;
endmodule
`default_nettype wire

// ===== tb/parallel_port_polarity_mode_tb.sv
/* Bench for pppm_top: pin table, master and slave cycles, irq.
   Assumes pppm_chk and pppm_host compiled first. */
`timescale 1ns/10ps
`default_nettype none
module parallel_port_polarity_mode_tb;
  logic        mclk;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] v;
  logic [15:0] ctl [5];
  logic [15:0] md [5];
  logic [15:0] ad [5];
  logic [3:0]  ex [5];
  logic [15:0] sm [3];
  logic [15:0] sa [3];
  logic [15:0] sb [3];
  int          n_fail = 0;
  int          check_count = 0;
  wire  [15:0] reg_rdata, port_address_pins, port_data_o, port_data_i, host_data;
  wire         port_data_oe, byte_enable_pin, write_strobe_pin, write_strobe_oe;
  wire         write_strobe_i, read_strobe_pin, read_strobe_oe, read_strobe_i;
  wire         irq, host_wr, host_rd;
  wire  [3:0]  pins = {byte_enable_pin, write_strobe_pin, read_strobe_pin, write_strobe_oe};
  assign port_data_i = port_data_oe ? port_data_o : host_data;
  assign write_strobe_i = write_strobe_oe ? write_strobe_pin : host_wr;
  assign read_strobe_i = read_strobe_oe ? read_strobe_pin : host_rd;
  pppm_top dut_u (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_address_pins(port_address_pins),
    .port_data_o(port_data_o), .port_data_oe(port_data_oe), .port_data_i(port_data_i),
    .byte_enable_pin(byte_enable_pin), .write_strobe_pin(write_strobe_pin),
    .write_strobe_oe(write_strobe_oe), .write_strobe_i(write_strobe_i),
    .read_strobe_pin(read_strobe_pin), .read_strobe_oe(read_strobe_oe),
    .read_strobe_i(read_strobe_i), .irq(irq));
  pppm_host host (.mclk(mclk), .host_wr(host_wr), .host_rd(host_rd), .host_data(host_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      check_count++;
      if (seen !== exp) begin
        n_fail++;
        $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task automatic report_and_stop();
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    begin
      rd_reg(a, d);
      check(d, e);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctl = '{16'h8707, 16'h8700, 16'h8007, 16'h8000, 16'h8702};
    md = '{16'h0000, 16'h0300, 16'h0300, 16'h0200, 16'h0200};
    ad = '{16'h0000, 16'h0000, 16'hE000, 16'h0000, 16'h0000};
    ex = '{4'h0, 4'hF, 4'hF, 4'h1, 4'hB};
    sm = '{16'h0A00, 16'h1200, 16'h0200};
    sa = '{16'h3FFF, 16'h8000, 16'h1234};
    sb = '{16'h8000, 16'h3FFF, 16'h1234};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(4'h0, 16'h0000);
    rd_chk(4'h1, 16'h0000);
    check({12'h000, pins}, 16'h0000);
    rd_chk(4'h7, 16'h0000);
    wr_reg(4'h7, 16'hFFFF);
    wr_reg(4'h0, 16'hFFFF);
    rd_chk(4'h0, 16'h8707);
    wr_reg(4'h1, 16'hFFFF);
    rd_chk(4'h1, 16'h7FFF);
    for (int i = 0; i < 5; i++) begin
      wr_reg(4'h0, ctl[i]);
      wr_reg(4'h1, md[i]);
      wr_reg(4'h2, ad[i]);
      @(posedge mclk);
      #1;
      check({12'h000, pins}, {12'h000, ex[i]});
    end
    wr_reg(4'h0, 16'h8700);
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h1, sm[i]);
      wr_reg(4'h2, sa[i]);
      wr_reg(4'h3, 16'h00AA);
      #1;
      check({12'h000, pins}, 16'h000F);
      @(posedge mclk);
      #1;
      check({12'h000, pins}, 16'h000B);
      repeat (2) @(posedge mclk);
      #1;
      check(port_address_pins, sb[i]);
    end
    // Wide first master mode read, cycle interrupt, step up
    wr_reg(4'h0, 16'h8707);
    wr_reg(4'h1, 16'h2F00);
    wr_reg(4'h6, 16'h0001);
    host.present(16'hC3C3);
    repeat (25) @(posedge mclk);
    rd_reg(4'h3, v);
    @(posedge mclk);
    #1;
    check({12'h000, pins}, 16'h000F);
    check({15'h0000, read_strobe_oe}, 16'h0001);
    repeat (2) @(posedge mclk);
    #1;
    check({15'h0000, irq}, 16'h0001);
    check(port_address_pins, 16'h1235);
    rd_chk(4'h3, 16'hC3C3);
    // That data read started a second transfer, so busy shows here
    rd_chk(4'h1, 16'hAF00);
    repeat (25) @(posedge mclk);
    rd_chk(4'h4, 16'h0001);
    wr_reg(4'h6, 16'h0000);
    #1;
    check({15'h0000, irq}, 16'h0000);
    wr_reg(4'h6, 16'h0001);
    #1;
    check({15'h0000, irq}, 16'h0001);
    wr_reg(4'h5, 16'hFFFF);
    #1;
    check({15'h0000, irq}, 16'h0000);
    rd_chk(4'h4, 16'h0000);
    // Slave cycles, active-low then active-high strobes
    wr_reg(4'h0, 16'h8700);
    wr_reg(4'h1, 16'h0100);
    host.cycle(1'b1, 1'b0, 16'h5A5A);
    repeat (2) @(posedge mclk);
    rd_chk(4'h8, 16'h5A5A);
    fork
      host.cycle(1'b0, 1'b0, 16'h0000);
      begin
        repeat (3) @(posedge mclk);
        #1;
        check(port_data_o, 16'h5A5A);
        check({15'h0000, port_data_oe}, 16'h0001);
      end
    join
    wr_reg(4'h0, 16'h0000);
    host.rest(1'b1);
    wr_reg(4'h0, 16'h8703);
    host.cycle(1'b1, 1'b1, 16'hA5A5);
    repeat (2) @(posedge mclk);
    rd_chk(4'h8, 16'hA5A5);
    wr_reg(4'h0, 16'h8503);
    host.cycle(1'b1, 1'b1, 16'h0F0F);
    repeat (2) @(posedge mclk);
    rd_chk(4'h8, 16'hA5A5);
    // Buffered slave with pointer stepping and buffer 3 event
    wr_reg(4'h1, 16'h7900);
    wr_reg(4'h0, 16'h8703);
    for (int k = 0; k < 4; k++) begin
      host.cycle(1'b1, 1'b1, 16'hB000 + 16'(k));
    end
    repeat (2) @(posedge mclk);
    rd_chk(4'h4, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      rd_chk(4'h8 + 4'(k), 16'hB000 + 16'(k));
    end
    host.cycle(1'b1, 1'b1, 16'hB004);
    repeat (2) @(posedge mclk);
    rd_chk(4'h8, 16'hB004);
    // Mid-run reset must bring back the quiet power-on state
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check({11'h000, irq, pins}, 16'h0000);
    rd_chk(4'h1, 16'h0000);
    rd_chk(4'h2, 16'h0000);
    rd_chk(4'h4, 16'h0000);
    report_and_stop();
  end
endmodule
bind pppm_top pppm_chk chk_u (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port_address_pins(port_address_pins), .port_data_oe(port_data_oe),
  .write_strobe_oe(write_strobe_oe), .read_strobe_oe(read_strobe_oe), .irq(irq));
`default_nettype wire

// ===== tb/pppm_chk.sv
/* Port checker for pppm_top.
   Assumes a bind from the bench and one clock. */
`timescale 1ns/10ps
`default_nettype none
module pppm_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] port_address_pins,
  input wire logic        port_data_oe,
  input wire logic        write_strobe_oe,
  input wire logic        read_strobe_oe,
  input wire logic        irq
);
  // Longest transfer is 24 cycles, so 25 quiet cycles mean not busy
  logic [4:0] quiet_r;
  wire        data_acc = (reg_wr | reg_rd) && reg_addr == 4'h3;
  wire        start_ok = data_acc && write_strobe_oe && quiet_r >= 5'h19;
  always @(posedge mclk or posedge rst) begin
    if (rst) quiet_r <= 5'h1F;
    else if (data_acc) quiet_r <= 5'h00;
    else if (quiet_r != 5'h1F) quiet_r <= quiet_r + 5'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wr_go; start_ok && reg_wr; endsequence
  sequence rd_go; start_ok && reg_rd; endsequence
  sequence wr_busy; port_data_oe [*3] ##[1:22] !port_data_oe; endsequence
  chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  chk_unmap_zero: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_oe_pair: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[15]
    |=> !write_strobe_oe && !read_strobe_oe)
    else $error("strobes driven while disabled");
  chk_wr_span: assert property (wr_go |=> wr_busy)
    else $error("write transfer span wrong");
  chk_rd_quiet: assert property (rd_go |=> !port_data_oe [*3])
    else $error("data driven in master read");
  chk_addr_hold: assert property (port_data_oe && $past(port_data_oe) && !$past(reg_wr)
    |-> $stable(port_address_pins))
    else $error("address moved mid transfer");
  chk_irq_mask: assert property (reg_wr && reg_addr == 4'h6 && reg_wdata == 16'h0000
    |=> !irq)
    else $error("irq high while masked");
  chk_irq_clear: assert property (reg_wr && reg_addr == 4'h5 && reg_wdata == 16'hFFFF
    && write_strobe_oe && quiet_r >= 5'h19 |=> !irq)
    else $error("irq kept after clear");
endmodule
`default_nettype wire

// ===== tb/pppm_host.sv
/* Host on the slave strobes and data lines.
   Assumes the bench resolves lines against the design's enables. */
`timescale 1ns/10ps
`default_nettype none
module pppm_host (
  input  wire logic        mclk,
  output var  logic        host_wr,
  output var  logic        host_rd,
  output var  logic [15:0] host_data
);
  // Inactive for the active-low setting after reset
  initial begin
    host_wr = 1'b1;
    host_rd = 1'b1;
    host_data = 16'hFFFF;
  end
  task automatic rest(input logic pol);
    begin
      @(posedge mclk);
      host_wr <= ~pol;
      host_rd <= ~pol;
    end
  endtask
  task automatic present(input logic [15:0] d);
    begin
      @(posedge mclk);
      host_data <= d;
    end
  endtask
  // Released data inverts so a stale value never passes
  task automatic cycle(input logic wr, input logic pol, input logic [15:0] d);
    begin
      @(posedge mclk);
      host_data <= d;
      if (wr) host_wr <= pol;
      else host_rd <= pol;
      repeat (3) @(posedge mclk);
      host_wr <= ~pol;
      host_rd <= ~pol;
      host_data <= ~d;
    end
  endtask
endmodule
`default_nettype wire
